//--- fbm_cfg.svh
/*
  timing counts, register offsets and field positions for the flash host controller.
  assumes a 25 MHz clk_i; included by its bare name.
*/
`ifndef FBM_CFG_SVH
`define FBM_CFG_SVH
`define FBM_CLK_MHZ          25
// pin timings in ns as printed defaults (device speed grade dependent)
`define FBM_ACC_NS           90
`define FBM_CE_NS            90
`define FBM_RP_NS            500
`define FBM_RH_NS            50
`define FBM_WP_NS            45
`define FBM_SLEEP_EXTRA_NS   30
// least times round up to whole cycles
`define FBM_CYC(ns)          (((ns) * `FBM_CLK_MHZ + 999) / 1000)
`define FBM_CE_CYC           `FBM_CYC(`FBM_CE_NS)
`define FBM_RP_CYC           `FBM_CYC(`FBM_RP_NS)
`define FBM_RH_CYC           `FBM_CYC(`FBM_RH_NS)
`define FBM_WP_CYC           `FBM_CYC(`FBM_WP_NS)
// wishbone register offsets (byte addresses)
`define FBM_REG_CTRL         8'h00
`define FBM_REG_ADDR         8'h04
`define FBM_REG_DATA         8'h08
`define FBM_REG_STAT         8'h0c
`define FBM_REG_SECT         8'h10
// control field positions
`define FBM_CTRL_GO          0
`define FBM_CTRL_WRITE       1
`define FBM_CTRL_RESET       2
`define FBM_CTRL_WORD        3
`define FBM_CTRL_BOTTOM      4
// status field positions
`define FBM_STAT_BUSY        0
`define FBM_STAT_RDY         1
`define FBM_STAT_DONE        2
`endif

//--- fbm_flash_model.sv
/* behavioural flash on the pins.
   assumes bus_i is the resolved data wire. */
`timescale 1ns/1ns
`default_nettype none
module fbm_flash_model (
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        clr_n_i,
  input  wire logic        wide_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [15:0] bus_i,
  output var  logic [15:0] dq_o,
  output var  logic        rb_n_o
);
  logic [15:0] mem [int];
  logic [18:0] lat;
  logic [15:0] last = 16'h0;
  logic [15:0] val;
  initial rb_n_o = 1'b1;
  // address on falling, data on rising write edge
  always @(negedge we_n_i) if (!ce_n_i) lat = addr_i;
  always @(posedge we_n_i) if (!ce_n_i && clr_n_i && oe_n_i) begin
    mem[lat] = bus_i;
    rb_n_o <= 1'b0;
    rb_n_o <= #400 1'b1;
  end
  always @(negedge clr_n_i) rb_n_o <= 1'b0;
  always @(posedge clr_n_i) rb_n_o <= #200 1'b1;
  // array read from start; a floating wire shows the inverse of the last value
  always @(oe_n_i, ce_n_i, we_n_i, clr_n_i, addr_i, bus_i[15], wide_i) begin
    val = mem.exists(addr_i) ? mem[addr_i] : ~addr_i[15:0];
    if (!wide_i) val = {~last[15:8], bus_i[15] ? val[15:8] : val[7:0]};
    if (!ce_n_i && !oe_n_i && clr_n_i && we_n_i) last = val;
    dq_o = (!ce_n_i && !oe_n_i && clr_n_i && we_n_i) ? val : ~last;
  end
endmodule : fbm_flash_model
`default_nettype wire

//--- fbm_host.sv
/*
  host controller for an asynchronous parallel nor flash: one bus cycle per software order.
  assumes a wishbone classic master on clk_i and a flash wired to the pin ports.
*/
// Summary of operation
// - in bypass mode a program is two write cycles; software issues them singly.
// - reads wait select access time after leaving standby before sampling.
// - host should restart interrupted program or erase after reset.
// - host waits reset to read time after reset pin rises.
// - write needs chip and write enable low, output enable high.
`timescale 1ns/1ns
`default_nettype none
`include "fbm_cfg.svh"
module fbm_host
  import fbm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  output var  logic        chip_enable_n_o,
  output var  logic        output_enable_n_o,
  output var  logic        write_enable_n_o,
  output var  logic        hw_clear_n_o,
  output var  logic        narrow_width_n_o,
  output var  logic [18:0] addr_o,
  output var  logic [15:0] dq_o,
  output var  logic [15:0] dq_oe_o,
  input  wire logic [15:0] dq_i,
  input  wire logic        ready_busy_n_i
);
  fbm_state_e  st_q, st_d;
  logic [4:0]  ctrl_q, ctrl_d;
  logic [19:0] adr_q, adr_d;
  logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        done_q, done_d, ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic        ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, clr_n_q, clr_n_d;
  logic [15:0] dqo_q, dqo_d, dqe_q, dqe_d;
  logic        rb_m_q, rb_q;
  logic [15:0] dq_m_q, dq_s_q;
  fbm_sector_t sector;
  logic        req, is_wr, word;

  // two-flop synchronisers on pins from the asynchronous device
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rb_m_q <= 1'b1;
      rb_q   <= 1'b1;
      dq_m_q <= 16'h0000;
      dq_s_q <= 16'h0000;
    end else begin
      rb_m_q <= ready_busy_n_i;
      rb_q   <= rb_m_q;
      dq_m_q <= dq_i;
      dq_s_q <= dq_m_q;
    end
  end

  fbm_sector_map u_map (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .bottom_i  (ctrl_q[`FBM_CTRL_BOTTOM]),
    .hi_addr_i (adr_q[19:13]),
    .sector_o  (sector)
  );

  assign req   = wb_cyc_i && wb_stb_i && !ack_q;
  assign word  = ctrl_q[`FBM_CTRL_WORD];
  assign is_wr = ctrl_q[`FBM_CTRL_WRITE];

  // bus slave, register file and pin sequencer
  always_comb begin
    st_d    = st_q;
    ctrl_d  = ctrl_q;
    adr_d   = adr_q;
    wdat_d  = wdat_q;
    rdat_d  = rdat_q;
    cnt_d   = cnt_q;
    done_d  = done_q;
    ack_d   = 1'b0;
    rd_d    = rd_q;
    ce_n_d  = ce_n_q;
    oe_n_d  = oe_n_q;
    we_n_d  = we_n_q;
    clr_n_d = clr_n_q;
    dqo_d   = dqo_q;
    dqe_d   = dqe_q;
    if (req) begin
      ack_d = 1'b1;                                   // one wait state, then ack
      rd_d  = 32'h0000_0000;
      case (wb_adr_i)
        `FBM_REG_CTRL: begin
          rd_d = {27'h0, ctrl_q};
          // mode bits frozen while busy, so a running cycle keeps its width and direction
          if (wb_we_i && wb_sel_i[0] && st_q == FBM_IDLE) begin
            ctrl_d = wb_dat_i[4:0] & 5'h1e;           // go self-clears; reset bit is stored
            if (wb_dat_i[`FBM_CTRL_RESET]) begin
              st_d   = FBM_RST;
              cnt_d  = 5'h00;
              done_d = 1'b0;
            end else if (wb_dat_i[`FBM_CTRL_GO]) begin
              st_d   = FBM_SETUP;
              cnt_d  = 5'h00;
              done_d = 1'b0;
            end
          end
        end
        `FBM_REG_ADDR: begin
          rd_d = {12'h0, adr_q};
          if (wb_we_i && st_q == FBM_IDLE) adr_d = wb_dat_i[19:0];
        end
        `FBM_REG_DATA: begin
          rd_d = {16'h0, rdat_q};
          if (wb_we_i && st_q == FBM_IDLE) wdat_d = wb_dat_i[15:0];
        end
        `FBM_REG_STAT: begin
          rd_d = {29'h0, done_q, rb_q, st_q != FBM_IDLE};
          if (wb_we_i && wb_dat_i[`FBM_STAT_DONE]) done_d = 1'b0;
        end
        `FBM_REG_SECT: rd_d = {27'h0, sector};
        default: rd_d = 32'h0000_0000;                // unmapped reads zero
      endcase
    end
    case (st_q)
      FBM_IDLE: begin
        // standby between cycles: both selects high, data pins released
        ce_n_d  = 1'b1;
        oe_n_d  = 1'b1;
        we_n_d  = 1'b1;
        clr_n_d = 1'b1;
        dqe_d   = 16'h0000;
      end
      FBM_SETUP: begin
        // leave standby: address and data settle before the write strobe; for reads output enable falls here too
        ce_n_d = 1'b0;
        oe_n_d = is_wr;
        we_n_d = 1'b1;
        dqo_d  = word ? wdat_q : {adr_q[0], 7'h00, wdat_q[7:0]};
        dqe_d  = is_wr ? (word ? 16'hffff : 16'h80ff) : (word ? 16'h0000 : 16'h8000);
        st_d   = FBM_PULSE;
        cnt_d  = 5'h00;
      end
      FBM_PULSE: begin
        we_n_d = !is_wr;
        cnt_d  = cnt_q + 5'h01;
        // reads wait select time plus two synchroniser stages
        if (is_wr ? (cnt_q >= 5'(`FBM_WP_CYC)) : (cnt_q >= 5'(`FBM_CE_CYC + 2))) begin
          if (!is_wr) rdat_d = word ? dq_s_q : {8'h00, dq_s_q[7:0]};
          we_n_d = 1'b1;                              // data latched on rising edge
          st_d = FBM_HOLD;
        end
      end
      FBM_HOLD: begin
        oe_n_d = 1'b1;
        ce_n_d = 1'b1;                                // device finishes alone
        dqe_d  = 16'h0000;
        done_d = 1'b1;
        st_d   = FBM_IDLE;
      end
      FBM_RST: begin
        // clear pin low with every strobe parked high, so no cycle is seen mid-pulse
        clr_n_d = 1'b0;
        ce_n_d  = 1'b1;
        oe_n_d  = 1'b1;
        we_n_d  = 1'b1;
        dqe_d   = 16'h0000;
        cnt_d   = cnt_q + 5'h01;
        if (cnt_q >= 5'(`FBM_RP_CYC)) begin
          st_d  = FBM_RREC;
          cnt_d = 5'h00;
        end
      end
      FBM_RREC: begin
        clr_n_d = 1'b1;
        cnt_d = (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
        if (cnt_q >= 5'(`FBM_RH_CYC) && rb_q) begin
          done_d = 1'b1;
          st_d   = FBM_IDLE;
        end
      end
      default: st_d = FBM_IDLE;
    endcase
  end

  // state and pin registers; every output leaves from here, so pins never glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= FBM_IDLE;
      ctrl_q  <= 5'h08;
      adr_q   <= 20'h00000;
      wdat_q  <= 16'h0000;
      rdat_q  <= 16'h0000;
      cnt_q   <= 5'h00;
      done_q  <= 1'b0;
      ack_q   <= 1'b0;
      rd_q    <= 32'h0000_0000;
      ce_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      clr_n_q <= 1'b1;
      dqo_q   <= 16'h0000;
      dqe_q   <= 16'h0000;
    end else begin
      st_q    <= st_d;
      ctrl_q  <= ctrl_d;
      adr_q   <= adr_d;
      wdat_q  <= wdat_d;
      rdat_q  <= rdat_d;
      cnt_q   <= cnt_d;
      done_q  <= done_d;
      ack_q   <= ack_d;
      rd_q    <= rd_d;
      ce_n_q  <= ce_n_d;
      oe_n_q  <= oe_n_d;
      we_n_q  <= we_n_d;
      clr_n_q <= clr_n_d;
      dqo_q   <= dqo_d;
      dqe_q   <= dqe_d;
    end
  end

  // address held steady between cycles lets the device sleep
  assign addr_o            = adr_q[19:1];
  assign narrow_width_n_o  = ctrl_q[`FBM_CTRL_WORD];
  assign chip_enable_n_o   = ce_n_q;
  assign output_enable_n_o = oe_n_q;
  assign write_enable_n_o  = we_n_q;
  assign hw_clear_n_o      = clr_n_q;
  assign dq_o              = dqo_q;
  assign dq_oe_o           = dqe_q;
  assign wb_ack_o          = ack_q;
  assign wb_dat_o          = rd_q;
endmodule : fbm_host
`default_nettype wire

//--- fbm_host_properties.sv
/* pin timing checks for fbm_host.
   assumes one clock, bound below. */
`timescale 1ns/1ns
`default_nettype none
`include "fbm_cfg.svh"
module fbm_host_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        chip_enable_n_o,
  input wire logic        output_enable_n_o,
  input wire logic        write_enable_n_o,
  input wire logic        hw_clear_n_o,
  input wire logic [18:0] addr_o,
  input wire logic [15:0] dq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int unsigned lo_cnt;
  // cycles the clear pin has been low; too long for a repetition count
  always_ff @(posedge clk_i) begin
    if (rst_i || hw_clear_n_o) lo_cnt <= 0;
    else                       lo_cnt <= lo_cnt + 1;
  end
  // strobe relations on the pins
  property p_wr; $fell(write_enable_n_o) |-> (!write_enable_n_o && !chip_enable_n_o && output_enable_n_o)[*2]; endproperty
  property p_wdq; !write_enable_n_o |-> dq_oe_o[7:0] == 8'hff; endproperty
  property p_rd; $fell(output_enable_n_o) |-> (!chip_enable_n_o && write_enable_n_o)[*4]; endproperty
  property p_oe; !output_enable_n_o |-> dq_oe_o[14:0] == 15'h0; endproperty
  property p_rh; $rose(hw_clear_n_o) |-> output_enable_n_o[*2]; endproperty
  property p_rp; $rose(hw_clear_n_o) |-> lo_cnt >= `FBM_RP_CYC; endproperty
  property p_idle; !hw_clear_n_o |-> chip_enable_n_o; endproperty
  property p_adr; !chip_enable_n_o && !$past(chip_enable_n_o) |-> $stable(addr_o); endproperty
  a_wr: assert property (p_wr) else $error("write strobe");
  a_wdq: assert property (p_wdq) else $error("write data off");
  a_rd: assert property (p_rd) else $error("read too short");
  a_oe: assert property (p_oe) else $error("drive in read");
  a_rh: assert property (p_rh) else $error("read after clear");
  a_rp: assert property (p_rp) else $error("clear too short");
  a_idle: assert property (p_idle) else $error("select in clear");
  a_adr: assert property (p_adr) else $error("addr moved");
  c_wr: cover property ($fell(write_enable_n_o));
  c_rd: cover property ($fell(output_enable_n_o));
  c_rp: cover property ($rose(hw_clear_n_o));
endmodule : fbm_host_properties
bind fbm_host fbm_host_properties fbm_host_properties_i (.clk_i, .rst_i, .chip_enable_n_o,
  .output_enable_n_o, .write_enable_n_o, .hw_clear_n_o, .addr_o, .dq_oe_o);
`default_nettype wire

//--- fbm_pkg.sv
/*
  types for the flash host controller.
  assumes nothing beyond the config header.
*/
package fbm_pkg;
  typedef enum logic [2:0] {
    FBM_IDLE  = 3'b000,
    FBM_SETUP = 3'b001,
    FBM_PULSE = 3'b010,
    FBM_HOLD  = 3'b011,
    FBM_RST   = 3'b100,
    FBM_RREC  = 3'b101
  } fbm_state_e;
  typedef logic [4:0] fbm_sector_t;
endpackage : fbm_pkg

//--- fbm_sector_map.sv
/*
  sector decoder: maps address bits 18..12 to a sector index for top or bottom boot.
  assumes a same-clock address input; result is registered.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fbm_cfg.svh"
module fbm_sector_map
  import fbm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        bottom_i,
  input  wire logic [6:0]  hi_addr_i,
  output var  fbm_sector_t sector_o
);
  fbm_sector_t sector_d;
  fbm_sector_t sector_q;

  // decode both boot layouts; small sectors sit at the boot end
  always_comb begin
    sector_d = 5'h00;
    if (!bottom_i) begin
      if (hi_addr_i[6:3] != 4'hf)
        sector_d = {1'b0, hi_addr_i[6:3]};
      else if (!hi_addr_i[2])
        sector_d = 5'h0f;
      else if (!hi_addr_i[1])
        sector_d = hi_addr_i[0] ? 5'h11 : 5'h10;
      else
        sector_d = 5'h12;
    end else begin
      if (hi_addr_i[6:3] != 4'h0)
        sector_d = 5'(hi_addr_i[6:3]) + 5'h03;
      else if (hi_addr_i[2])
        sector_d = 5'h03;
      else if (hi_addr_i[1])
        sector_d = hi_addr_i[0] ? 5'h02 : 5'h01;
      else
        sector_d = 5'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) sector_q <= 5'h00;
    else       sector_q <= sector_d;
  end
  assign sector_o = sector_q;
endmodule : fbm_sector_map
`default_nettype wire

//--- tb_top.sv
/* self-checking bench for fbm_host.
   wishbone driven here, flash model on the pins. */
`timescale 1ns/1ns
`default_nettype none
`include "fbm_cfg.svh"
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic        ack, ce_n, oe_n, we_n, clr_n, wide, rb_n;
  logic [18:0] fa;
  logic [15:0] hq, hoe, dev, bus;
  int          miscompares = 0;
  int          n_compared = 0;
  int          lo_n = 0;
  int          mem [int];
  always #20 clk_i = ~clk_i;
  // host bits win where enabled
  assign bus = (hoe & hq) | (~hoe & dev);
  fbm_host fbm_host_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .chip_enable_n_o(ce_n),
    .output_enable_n_o(oe_n), .write_enable_n_o(we_n), .hw_clear_n_o(clr_n), .narrow_width_n_o(wide),
    .addr_o(fa), .dq_o(hq), .dq_oe_o(hoe), .dq_i(bus), .ready_busy_n_i(rb_n));
  fbm_flash_model fbm_flash_model_i (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .clr_n_i(clr_n),
    .wide_i(wide), .addr_i(fa), .bus_i(bus), .dq_o(dev), .rb_n_o(rb_n));
  // length of the clear pulse in cycles
  always @(posedge clk_i) lo_n <= clr_n ? 0 : lo_n + 1;
  always @(posedge clr_n) if (!rst_i) check("clear_len", 32'(lo_n >= `FBM_RP_CYC), 1);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // one classic cycle, held until ack is sampled
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
  endtask : wb
  task automatic op(logic [7:0] a, logic [31:0] d, logic go);
    logic [31:0] s;
    wb(1'b1, a, d, s);
    if (go) begin
      do wb(1'b0, `FBM_REG_STAT, 0, s); while (s[`FBM_STAT_DONE] !== 1'b1);
      wb(1'b1, `FBM_REG_STAT, 32'h4, s);
    end
  endtask : op
  // sector index expected from the boot tables
  function automatic int sect(logic b, logic [6:0] a);
    if (b) return a[6:3] != 0 ? a[6:3] + 3 : a[2] ? 3 : a[1] ? 1 + a[0] : 0;
    return a[6:3] != 15 ? a[6:3] : !a[2] ? 15 : !a[1] ? 16 + a[0] : 18;
  endfunction : sect
  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end
  initial begin
    logic [31:0] q, a, d;
    void'($urandom(56399));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `FBM_REG_CTRL, 0, q);
    check("ctrl", q, 32'h8);
    wb(1'b0, 8'h14, 0, q);
    check("unmapped", q, 0);
    // bypass program: command word then data, then read back word and byte
    for (int i = 0; i < 5; i++) begin
      a = $urandom & 32'hffffe;
      d = $urandom & 32'hffff;
      op(`FBM_REG_ADDR, a, 0);
      for (int j = 0; j < 2; j++) begin
        op(`FBM_REG_DATA, j ? d : 32'ha0, 0);
        op(`FBM_REG_CTRL, 32'h0b, 1);
      end
      mem[a >> 1] = d;
      op(`FBM_REG_CTRL, 32'h09, 1);
      wb(1'b0, `FBM_REG_DATA, 0, q);
      check("word_rd", q, mem[a >> 1]);
      op(`FBM_REG_ADDR, a | 1, 0);
      op(`FBM_REG_CTRL, 32'h01, 1);
      wb(1'b0, `FBM_REG_DATA, 0, q);
      check("byte_rd", q, mem[a >> 1] >> 8);
    end
    // clear pulse while the last program is still busy, then array read
    op(`FBM_REG_ADDR, a, 0);
    op(`FBM_REG_CTRL, 32'h0b, 1);
    op(`FBM_REG_CTRL, 32'h0d, 1);
    wb(1'b0, `FBM_REG_STAT, 0, q);
    check("ready", q[`FBM_STAT_RDY], 1);
    // the cut program is issued again once the device accepts commands
    op(`FBM_REG_CTRL, 32'h0b, 1);
    op(`FBM_REG_CTRL, 32'h09, 1);
    wb(1'b0, `FBM_REG_DATA, 0, q);
    check("after_clear", q, mem[a >> 1]);
    // every top pattern then every bottom pattern
    for (int i = 0; i < 256; i++) begin
      op(`FBM_REG_CTRL, i[7] ? 32'h18 : 32'h08, 0);
      op(`FBM_REG_ADDR, {12'h0, i[6:0], 13'($urandom)}, 0);
      wb(1'b0, `FBM_REG_SECT, 0, q);
      check("sector", q, sect(i[7], i[6:0]));
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
